/* rtl/asb_pkg.sv */
// shared constants, types and decode helpers for the serial receiver block
package asb_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  localparam logic [7:0] OFF_BAUD = 8'h10;
  localparam logic [7:0] OFF_TXFINE = 8'h14;
  localparam logic [7:0] OFF_RXFINE = 8'h18;
  localparam logic [7:0] OFF_INTSTAT = 8'h1c;
  localparam logic [7:0] OFF_INTEN = 8'h20;
  localparam logic [7:0] OFF_INTCLR = 8'h24;
  localparam int C1_NINE = 0;
  localparam int C1_WAKE = 1;
  localparam int C1_RX8 = 7;
  localparam int C2_RXEN = 0;
  localparam int C2_TXEN = 1;
  localparam int C2_MUTE = 2;
  localparam int ST_FULL = 0;
  localparam int ST_FERR = 1;
  localparam int ST_IDLE = 2;
  localparam int INT_RX = 0;
  localparam int INT_IDLE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] PR_F0 = 4'h1;
  localparam logic [3:0] PR_F1 = 4'h3;
  localparam logic [3:0] PR_F2 = 4'h4;
  localparam logic [3:0] PR_F3 = 4'hd;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [3:0] LAST_SAMPLE = 4'hf;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam int FRAME_BITS8 = 10;
  localparam int FRAME_BITS9 = 11;
  localparam logic [7:0] IDLE_TICKS8 = 8'(FRAME_BITS8 * OVERSAMPLE);
  localparam logic [7:0] IDLE_TICKS9 = 8'(FRAME_BITS9 * OVERSAMPLE);

  typedef struct packed {
    logic [8:0] data;
    logic frameErr;
  } asb_frame_t;

  typedef struct packed {
    logic [2:0] rxDiv;
    logic [2:0] txDiv;
    logic [1:0] prescale;
  } asb_baud_t;

  // word-address match, byte offset bits ignored
  function automatic logic asb_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : asb_hit

  // cycles per oversample tick, minus one
  function automatic logic [18:0] asb_period(input logic [1:0] ps, input logic [2:0] dv,
                                             input logic [7:0] fine);
    logic [3:0] pr;
    logic [7:0] fe;
    pr = (ps == 2'h0) ? PR_F0 : (ps == 2'h1) ? PR_F1 : (ps == 2'h2) ? PR_F2 : PR_F3;
    fe = (fine == 8'h00) ? 8'h01 : fine;
    return ((19'(pr) * 19'(fe)) << dv) - 19'h1;
  endfunction : asb_period
endpackage : asb_pkg

/* rtl/asb_baud_gen.sv */
// oversample tick generator for one direction
module asb_baud_gen import asb_pkg::*; (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset
  input wire logic enable, // direction enabled
  input wire logic [18:0] period, // cycles per tick minus one
  output logic tickReg // one-cycle oversample tick
);
  logic [18:0] cntReg;
  logic [18:0] cntNext;
  logic hitEnd;
  assign hitEnd = enable && (cntReg == period);
  assign cntNext = (!enable || hitEnd) ? 19'h0 : cntReg + 19'h1;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cntReg <= 19'h0;
      tickReg <= 1'b0;
    end else begin
      cntReg <= cntNext;
      tickReg <= hitEnd;
    end
  end

  logic [18:0] sinceCnt;
  logic seenReg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sinceCnt <= 19'h0;
      seenReg <= 1'b0;
    end else begin
      sinceCnt <= tickReg ? 19'h0 : sinceCnt + 19'h1;
      seenReg <= enable && (seenReg || tickReg);
    end
  end

  a_tick_spacing: assert property (@(posedge mclk) disable iff (rst)
    tickReg && seenReg && enable && $stable(period) |-> sinceCnt == period)
    else $error("tick spacing differs from programmed period");
endmodule : asb_baud_gen

/* rtl/asb_rx_core.sv */
// receive shifter: start, data, stop and idle-line detection
module asb_rx_core import asb_pkg::*; (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset
  input wire logic enable, // receiver enabled
  input wire logic tick, // oversample tick
  input wire logic rxLine, // filtered line level
  input wire logic nineBit, // 9-bit words
  output logic frameDone, // one-cycle frame end
  output asb_frame_t frame, // received word and stop status
  output logic idleDone // one-cycle idle frame seen
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_STOP, S_WAITHI} asb_rx_state_t;
  asb_rx_state_t state;
  logic [3:0] sampCnt;
  logic [3:0] bitIdx;
  logic [8:0] shiftReg;
  logic [7:0] idleCnt;
  wire [3:0] lastBit = nineBit ? LAST_BIT9 : LAST_BIT8;
  wire [7:0] idleLen = nineBit ? IDLE_TICKS9 : IDLE_TICKS8;
  wire atMid = tick && (sampCnt == MID_SAMPLE);
  wire atLast = tick && (sampCnt == LAST_SAMPLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      sampCnt <= 4'h0;
      bitIdx <= 4'h0;
      shiftReg <= 9'h0;
      idleCnt <= 8'h0;
      frameDone <= 1'b0;
      frame <= '0;
      idleDone <= 1'b0;
    end else begin
      frameDone <= 1'b0;
      idleDone <= 1'b0;
      if (tick) begin
        sampCnt <= sampCnt + 4'h1;
      end
      if (!enable) begin
        state <= S_IDLE;
        idleCnt <= 8'h0;
      end else begin
        case (state)
          S_IDLE: begin
            if (!rxLine) begin
              state <= S_START;
              sampCnt <= 4'h0;
              shiftReg <= 9'h0;
              idleCnt <= 8'h0;
            end else if (tick && idleCnt != idleLen) begin
              idleCnt <= idleCnt + 8'h1;
              idleDone <= (idleCnt == idleLen - 8'h1);
            end
          end
          S_START: begin
            if (atMid && rxLine) begin
              state <= S_IDLE;
            end else if (atLast) begin
              state <= S_DATA;
              bitIdx <= 4'h0;
            end
          end
          S_DATA: begin
            if (atMid) begin
              shiftReg[bitIdx] <= rxLine;
            end
            if (atLast) begin
              if (bitIdx == lastBit) begin
                state <= S_STOP;
              end else begin
                bitIdx <= bitIdx + 4'h1;
              end
            end
          end
          S_STOP: begin
            if (atMid) begin
              frameDone <= 1'b1;
              frame.data <= shiftReg;
              frame.frameErr <= !rxLine;
              state <= rxLine ? S_IDLE : S_WAITHI;
            end
          end
          S_WAITHI: begin
            if (rxLine) begin
              state <= S_IDLE;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule : asb_rx_core

/* rtl/asb_serial_rx.sv */
// serial receiver with baud generation, mute/wake and AXI4-Lite registers
// Overview of operation
// - missing stop bit or break sets frame error flag
// - frame error still loads received word into data buffer
// - frame error has no own interrupt; rises with rx full flag
// - frame error clears only by status read then data read
// - baud is clock over 16, shared prescale and direction divider, independently
// - three-bit tx and rx divider fields select powers of two 1..128
// - fine prescaler divides further by 1..255, per direction register
// - fine prescaler zero means conventional divider only
// - while muted no reception flags and no receive interrupts
// - wake bit selects idle-line or address-mark wake source
// - idle wake clears mute without setting idle flag
// - address mark word clears mute and is received normally
// - nine-bit mode stores received top bit in control 1
// - completed word sets rx full flag in the same cycle as buffer load
// - data arrives least significant bit first
module asb_serial_rx import asb_pkg::*; (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic rxLinePin, // receive line pin
  output logic txBaudTick, // transmit oversample tick
  output logic irq // level interrupt
);
  // line synchroniser; change accepted when stages 2 and 3 agree
  logic [2:0] syncReg;
  logic rxLine;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncReg <= 3'h7;
      rxLine <= 1'b1;
    end else begin
      syncReg <= {syncReg[1:0], rxLinePin};
      if (syncReg[1] == syncReg[2]) begin
        rxLine <= syncReg[2];
      end
    end
  end

  // software state
  logic nineBitReg, wakeReg, rxEnReg, txEnReg, muteReg;
  asb_baud_t baudReg;
  logic [7:0] txFineReg, rxFineReg;
  logic [1:0] intEnReg, intStatReg;
  // hardware flags
  logic rxFullReg, feReg, idleReg, armedReg, rx8Reg;
  logic [7:0] dataBufReg;

  // write channel
  logic awHeld, wHeld;
  logic [7:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  wire doWrite = awHeld && wHeld && !bvalid;
  wire wrEn = doWrite && wStrbReg[0];
  wire [7:0] wd = wDataReg[7:0];
  wire wrCtrl1 = wrEn && asb_hit(awAddrReg, OFF_CTRL1);
  wire wrCtrl2 = wrEn && asb_hit(awAddrReg, OFF_CTRL2);
  wire wrBaud = wrEn && asb_hit(awAddrReg, OFF_BAUD);
  wire wrTxFine = wrEn && asb_hit(awAddrReg, OFF_TXFINE);
  wire wrRxFine = wrEn && asb_hit(awAddrReg, OFF_RXFINE);
  wire wrIntEn = wrEn && asb_hit(awAddrReg, OFF_INTEN);
  wire wrIntClr = wrEn && asb_hit(awAddrReg, OFF_INTCLR);
  wire wrHit = asb_hit(awAddrReg, OFF_CTRL1) || asb_hit(awAddrReg, OFF_CTRL2)
    || asb_hit(awAddrReg, OFF_STATUS) || asb_hit(awAddrReg, OFF_DATA)
    || asb_hit(awAddrReg, OFF_BAUD) || asb_hit(awAddrReg, OFF_TXFINE)
    || asb_hit(awAddrReg, OFF_RXFINE) || asb_hit(awAddrReg, OFF_INTSTAT)
    || asb_hit(awAddrReg, OFF_INTEN) || asb_hit(awAddrReg, OFF_INTCLR);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 32'h0;
      wStrbReg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrReg <= awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataReg <= wdata;
        wStrbReg <= wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // baud generation, one generator per direction
  wire [18:0] txPeriod = asb_period(baudReg.prescale, baudReg.txDiv, txFineReg);
  wire [18:0] rxPeriod = asb_period(baudReg.prescale, baudReg.rxDiv, rxFineReg);
  logic rxTick;
  asb_baud_gen u_tx_baud (
    .mclk(mclk),
    .rst(rst),
    .enable(txEnReg),
    .period(txPeriod),
    .tickReg(txBaudTick)
  );
  asb_baud_gen u_rx_baud (
    .mclk(mclk),
    .rst(rst),
    .enable(rxEnReg),
    .period(rxPeriod),
    .tickReg(rxTick)
  );

  // receiver
  logic frameDone, idleDone;
  asb_frame_t rxFrame;
  asb_rx_core u_rx (
    .mclk(mclk),
    .rst(rst),
    .enable(rxEnReg),
    .tick(rxTick),
    .rxLine(rxLine),
    .nineBit(nineBitReg),
    .frameDone(frameDone),
    .frame(rxFrame),
    .idleDone(idleDone)
  );

  // flag and mute logic
  wire frameMsb = nineBitReg ? rxFrame.data[8] : rxFrame.data[7];
  wire addrWake = frameDone && muteReg && wakeReg && frameMsb;
  wire idleWake = idleDone && muteReg && !wakeReg;
  wire accept = frameDone && (!muteReg || addrWake) && !rxFullReg;
  wire idleSet = idleDone && !muteReg;
  wire rdTake = arvalid && arready;
  wire statusRead = rdTake && asb_hit(araddr, OFF_STATUS);
  wire dataRead = rdTake && asb_hit(araddr, OFF_DATA);
  wire clearSeq = dataRead && armedReg;
  // a software write of the mute bit wins over a wake in the same cycle
  wire muteNext = wrCtrl2 ? wd[C2_MUTE] : (muteReg && !addrWake && !idleWake);
  wire [1:0] intEvt = {idleSet, accept};
  wire [1:0] intClr = wrIntClr ? wd[1:0] : 2'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nineBitReg <= 1'b0;
      wakeReg <= 1'b0;
      rxEnReg <= 1'b0;
      txEnReg <= 1'b0;
      muteReg <= 1'b0;
      baudReg <= '0;
      txFineReg <= 8'h00;
      rxFineReg <= 8'h00;
      intEnReg <= 2'h0;
      intStatReg <= 2'h0;
      rxFullReg <= 1'b0;
      feReg <= 1'b0;
      idleReg <= 1'b0;
      armedReg <= 1'b0;
      rx8Reg <= 1'b0;
      dataBufReg <= 8'h00;
    end else begin
      if (wrCtrl1) begin
        nineBitReg <= wd[C1_NINE];
        wakeReg <= wd[C1_WAKE];
      end
      if (wrCtrl2) begin
        rxEnReg <= wd[C2_RXEN];
        txEnReg <= wd[C2_TXEN];
      end
      muteReg <= muteNext;
      if (wrBaud) baudReg <= wd;
      if (wrTxFine) txFineReg <= wd;
      if (wrRxFine) rxFineReg <= wd;
      if (wrIntEn) intEnReg <= wd[1:0];
      intStatReg <= intEvt | (intStatReg & ~intClr);
      rxFullReg <= accept || (rxFullReg && !clearSeq);
      feReg <= (accept && rxFrame.frameErr) || (feReg && !clearSeq);
      idleReg <= idleSet || (idleReg && !clearSeq);
      armedReg <= statusRead || (armedReg && !clearSeq);
      if (accept) begin
        dataBufReg <= rxFrame.data[7:0];
        rx8Reg <= rxFrame.data[8];
      end
    end
  end

  // frame error rides on the receive interrupt only
  assign irq = |(intStatReg & intEnReg);

  // read channel
  wire [31:0] ctrl1Word = 32'({rx8Reg, 5'h0, wakeReg, nineBitReg});
  wire [31:0] ctrl2Word = 32'({muteReg, txEnReg, rxEnReg});
  wire [31:0] statWord = 32'({idleReg, feReg, rxFullReg});
  wire rdHit = asb_hit(araddr, OFF_CTRL1) || asb_hit(araddr, OFF_CTRL2)
    || asb_hit(araddr, OFF_STATUS) || asb_hit(araddr, OFF_DATA)
    || asb_hit(araddr, OFF_BAUD) || asb_hit(araddr, OFF_TXFINE)
    || asb_hit(araddr, OFF_RXFINE) || asb_hit(araddr, OFF_INTSTAT)
    || asb_hit(araddr, OFF_INTEN) || asb_hit(araddr, OFF_INTCLR);
  wire [31:0] rdWord =
      ({32{asb_hit(araddr, OFF_CTRL1)}} & ctrl1Word)
    | ({32{asb_hit(araddr, OFF_CTRL2)}} & ctrl2Word)
    | ({32{asb_hit(araddr, OFF_STATUS)}} & statWord)
    | ({32{asb_hit(araddr, OFF_DATA)}} & 32'(dataBufReg))
    | ({32{asb_hit(araddr, OFF_BAUD)}} & 32'(baudReg))
    | ({32{asb_hit(araddr, OFF_TXFINE)}} & 32'(txFineReg))
    | ({32{asb_hit(araddr, OFF_RXFINE)}} & 32'(rxFineReg))
    | ({32{asb_hit(araddr, OFF_INTSTAT)}} & 32'(intStatReg))
    | ({32{asb_hit(araddr, OFF_INTEN)}} & 32'(intEnReg));
  assign arready = !rvalid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (rdTake) begin
      rvalid <= 1'b1;
      rdata <= rdWord;
      rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sAddrWake;
    frameDone && muteReg && wakeReg && frameMsb && !rxFullReg && !wrCtrl2;
  endsequence
  sequence sIdleWake;
    idleDone && muteReg && !wakeReg && !wrCtrl2 && !idleReg;
  endsequence
  sequence sClearSeq;
    dataRead && armedReg && !frameDone && !idleDone;
  endsequence

  a_fe_with_full: assert property ($rose(feReg) |-> $rose(rxFullReg))
    else $error("frame error rose without rx full");
  a_fe_irq_shared: assert property ($rose(feReg) |-> intStatReg[INT_RX])
    else $error("frame error without receive event");
  a_fe_loads_data: assert property (frameDone && rxFrame.frameErr
    && !muteReg && !rxFullReg |=> feReg && rxFullReg && dataBufReg == $past(rxFrame.data[7:0]))
    else $error("framing error frame not loaded");
  a_fe_clear_seq: assert property (feReg && dataRead && !armedReg |=> feReg)
    else $error("frame error cleared without status read");
  a_seq_clears: assert property (sClearSeq |=> !feReg && !rxFullReg && !idleReg)
    else $error("clear sequence left flags set");
  a_mute_blocks: assert property ($rose(rxFullReg)
    |-> !$past(muteReg) || $past(addrWake))
    else $error("flag set while muted");
  a_mute_quiet: assert property (muteReg && !addrWake
    |=> !$rose(rxFullReg) && !$rose(feReg) && !$rose(idleReg) && !$rose(intStatReg[INT_RX]))
    else $error("muted receiver raised a flag");
  a_mute_write: assert property (wrCtrl2 |=> muteReg == $past(wd[C2_MUTE]))
    else $error("mute bit differs from software write");
  a_idle_wake: assert property (sIdleWake |=> !muteReg && !idleReg)
    else $error("idle wake misbehaved");
  a_addr_wake: assert property (sAddrWake |=> !muteReg && rxFullReg
    ##1 (rxFullReg || $past(clearSeq)))
    else $error("address mark did not wake receiver");
  a_accept_loads: assert property (accept
    |=> rxFullReg && dataBufReg == $past(rxFrame.data[7:0]))
    else $error("accepted word not buffered");
  a_ninth_bit: assert property (accept && nineBitReg
    |=> rx8Reg == $past(rxFrame.data[8]))
    else $error("ninth bit not stored");
  a_irq_level: assert property ($rose(rxFullReg) && intEnReg[INT_RX]
    |-> irq ##1 (irq || $past(wrIntClr) || $past(wrIntEn)))
    else $error("receive interrupt missing");

  // bus answers one and two cycles after the request is taken
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write answer late");
endmodule : asb_serial_rx

/* bench/asb_remote_node.sv */
// remote serial node model driving the receive line
module asb_remote_node (
  output logic lineOut, // serial line, idle high
  input wire logic mclk // system clock
);
  timeunit 1ns;
  timeprecision 1ns;

  initial lineOut = 1'b1;

  // start bit, data lsb first, then stop; a low stop with zero data makes a break
  task automatic send_word(input logic [8:0] w, input logic nine, input logic stopOk,
                           input int bitCyc);
    logic [10:0] bits;
    int n;
    bits = nine ? {stopOk, w, 1'b0} : {1'b1, stopOk, w[7:0], 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      lineOut <= bits[i];
      repeat (bitCyc - 1) @(posedge mclk);
    end
    @(posedge mclk);
    lineOut <= 1'b1;
  endtask : send_word
endmodule : asb_remote_node

/* bench/test_asb_serial_rx.sv */
// self-checking bench for the serial receiver block
module test_asb_serial_rx import asb_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [1:0] ps;
    logic [2:0] dv;
    logic [7:0] fine;
    int per;
  } asb_row_t;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxLine, txBaudTick, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  int errors = 0;
  int n_checks = 0;
  int p;
  // prescale select, tx divider select, fine factor, expected tick period
  asb_row_t rows[9] = '{'{2'h0, 3'h0, 8'h00, 1}, '{2'h1, 3'h0, 8'h00, 3},
    '{2'h2, 3'h0, 8'h00, 4}, '{2'h3, 3'h0, 8'h00, 13}, '{2'h0, 3'h7, 8'h00, 128},
    '{2'h0, 3'h3, 8'h00, 8}, '{2'h1, 3'h1, 8'h05, 30}, '{2'h0, 3'h0, 8'hff, 255},
    '{2'h3, 3'h7, 8'h00, 1664}};

  always #25 mclk = ~mclk;

  asb_serial_rx DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rxLinePin(rxLine), .txBaudTick(txBaudTick), .irq(irq));

  asb_remote_node remote (.lineOut(rxLine), .mclk(mclk));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic give_up(input string nm);
    errors++;
    $display("BAD %s expected answer seen none", nm);
    tally_and_finish();
  endtask : give_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100 && !tb; i++) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) give_up("write");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100 && !tr; i++) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) give_up("read");
  endtask : rd

  task automatic measure();
    for (int i = 0; i < 4000 && txBaudTick !== 1'b1; i++) @(negedge mclk);
    p = 0;
    do begin
      @(negedge mclk);
      p++;
    end while (txBaudTick !== 1'b1 && p < 4000);
    if (txBaudTick !== 1'b1) give_up("tick");
  endtask : measure

  task automatic rx_case(input logic [8:0] w, input logic nine, input logic stopOk,
                         input logic [31:0] st);
    remote.send_word(w, nine, stopOk, 32);
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(negedge mclk);
    if (irq !== 1'b1) give_up("irq");
    check("irq raised", irq, 1);
    rd(OFF_DATA);
    rd(OFF_STATUS);
    check("status", v & 32'h3, st);
    rd(OFF_DATA);
    check("data", v, {24'h0, w[7:0]});
    rd(OFF_STATUS);
    check("status cleared", v & 32'h3, 0);
    rd(OFF_DATA);
    rd(OFF_INTSTAT);
    check("intstat", v & 32'h3, 1);
    wr(OFF_INTEN, 0);
    check("irq masked", irq, 0);
    wr(OFF_INTCLR, 3);
    wr(OFF_INTEN, 1);
    check("irq cleared", irq, 0);
  endtask : rx_case

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    check("irq reset", irq, 0);
    rd(OFF_STATUS);
    check("status reset", v, 0);
    rd(8'h40);
    check("rresp unmapped", r, RESP_SLVERR);
    check("rdata unmapped", v, 0);
    wr(8'h40, 32'h0);
    check("bresp unmapped", r, RESP_SLVERR);
    foreach (rows[k]) begin
      wr(OFF_CTRL2, 0);
      wr(OFF_BAUD, {24'h0, 3'h0, rows[k].dv, rows[k].ps});
      check("bresp", r, RESP_OKAY);
      wr(OFF_TXFINE, {24'h0, rows[k].fine});
      wr(OFF_CTRL2, 32'h2);
      measure();
      check("tick period", p, rows[k].per);
    end
    // receive with rx divider 2, fine prescale off: 32 cycles a bit
    wr(OFF_CTRL2, 0);
    wr(OFF_BAUD, 32'h20);
    wr(OFF_RXFINE, 0);
    wr(OFF_INTEN, 1);
    wr(OFF_CTRL2, 1);
    rd(OFF_DATA);
    rx_case(9'h0a5, 1'b0, 1'b1, 1);
    rx_case(9'h03c, 1'b0, 1'b0, 3);
    rx_case(9'h000, 1'b0, 1'b0, 3);
    // muted nine-bit receiver, address-mark wake
    wr(OFF_CTRL2, 0);
    wr(OFF_CTRL1, 3);
    wr(OFF_CTRL2, 5);
    remote.send_word(9'h0d5, 1'b1, 1'b1, 32);
    repeat (8) @(posedge mclk);
    check("irq muted", irq, 0);
    rd(OFF_STATUS);
    check("status muted", v & 32'h3, 0);
    // disarm so the wake word is not cleared early
    rd(OFF_DATA);
    rx_case(9'h1a3, 1'b1, 1'b1, 1);
    rd(OFF_CTRL1);
    check("ninth bit", v[7], 1);
    rd(OFF_CTRL2);
    check("ctrl2 woken", v, 1);
    // idle-line wake from a fresh enable
    wr(OFF_CTRL2, 0);
    wr(OFF_CTRL1, 0);
    rd(OFF_STATUS);
    rd(OFF_DATA);
    wr(OFF_INTCLR, 3);
    wr(OFF_INTEN, 3);
    wr(OFF_CTRL2, 5);
    repeat (450) @(posedge mclk);
    rd(OFF_CTRL2);
    check("ctrl2 idle woken", v, 1);
    rd(OFF_STATUS);
    check("idle flag", v & 32'h4, 0);
    check("irq idle", irq, 0);
    // mid-run reset returns control to defaults
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(OFF_CTRL2);
    check("ctrl2 after reset", v, 0);
    check("irq after reset", irq, 0);
    tally_and_finish();
  end
endmodule : test_asb_serial_rx
